// ==== src/five_level_inverter_gate_pwm.sv ====
// Behaviour
// - Three gate signals plus their complements.
// - Polarity select toggles at line frequency.
// - Cell carriers programmable 16 to 20 kHz.
// - One output drives each series pair.
// - Two legs run in antiphase.
// - Positive half: cell patterns give levels.
// - Negative half: cell patterns give levels.
// - Alternate redundant states for capacitor balance.
// - Combined cells ripple at twice frequency.
// - Reach nominal output within 500 ms.
// - Inhibit switching outside 380-420 V input.
// - Stop switching on overload or short.
// - Two carriers shifted by 180 degrees.
// - Cell high while reference exceeds carrier.
module five_level_inverter_gate_pwm
    import gate_pwm_pkg::*;
#(
    parameter int unsigned STARTUP_LEN = STARTUP_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [CNT_W-1:0] i_half_period,
    input wire logic [7:0] i_dead_cycles,
    input wire logic [15:0] i_depth,
    input wire logic [9:0] i_vin_volts,
    input wire logic i_overload,
    input wire logic i_short_circuit,
    input wire logic i_fault_clear,
    output logic o_polarity_select,
    output logic o_polarity_select_n,
    output logic o_cell_a_pwm,
    output logic o_cell_a_pwm_n,
    output logic o_cell_b_pwm,
    output logic o_cell_b_pwm_n,
    output logic o_running,
    output logic o_startup_done,
    output logic o_input_undervoltage_guard,
    output logic o_input_overvoltage_guard,
    output logic o_fault
);
    if (STARTUP_LEN < RAMP_STEPS) begin : g_bad_len
        $error("STARTUP_LEN too small");
    end

    function automatic logic [CNT_W-1:0] clamp_half(
        input logic [CNT_W-1:0] h);
        if (h < CNT_W'(HALF_PERIOD_MIN)) clamp_half = CNT_W'(HALF_PERIOD_MIN);
        else if (h > CNT_W'(HALF_PERIOD_MAX))
            clamp_half = CNT_W'(HALF_PERIOD_MAX);
        else clamp_half = h;
    endfunction

    // =====================================================
    // Protection
    logic uv, ov, trip;
    assign uv = i_vin_volts < 10'(VIN_MIN_V);
    assign ov = i_vin_volts > 10'(VIN_MAX_V);
    assign trip = uv | ov | i_overload | i_short_circuit;

    // =====================================================
    // Run state and start-up ramp
    run_state_type state_reg, state_next;
    logic [31:0] ramp_cnt_reg, ramp_cnt_next;
    logic [15:0] amp_reg, amp_next;
    logic fault_reg, fault_next;
    localparam int unsigned STEP_LEN = STARTUP_LEN / RAMP_STEPS;
    localparam logic [15:0] AMP_STEP = 16'(65536 / RAMP_STEPS);

    always_comb begin
        state_next = state_reg;
        ramp_cnt_next = ramp_cnt_reg;
        amp_next = amp_reg;
        fault_next = fault_reg;
        case (state_reg)
            ST_IDLE: begin
                amp_next = 16'h0000;
                if (i_start && !trip) begin
                    state_next = ST_RAMP;
                    ramp_cnt_next = 32'h0;
                end
            end
            ST_RAMP: begin
                // Linear ramp finishes before the start-up bound
                if (ramp_cnt_reg >= 32'(STEP_LEN - 1)) begin
                    ramp_cnt_next = 32'h0;
                    // Wide sum keeps depths near full scale from wrapping the ramp
                    if (17'(amp_reg) + 17'(AMP_STEP) >= 17'(i_depth)) begin
                        amp_next = i_depth;
                        state_next = ST_RUN;
                    end else begin
                        amp_next = amp_reg + AMP_STEP;
                    end
                end else begin
                    ramp_cnt_next = ramp_cnt_reg + 32'h1;
                end
            end
            ST_RUN: begin
                amp_next = i_depth;
            end
            ST_FAULT: begin
                amp_next = 16'h0000;
                if (i_fault_clear && !trip) begin
                    state_next = ST_IDLE;
                    fault_next = 1'b0;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        if (state_reg != ST_FAULT && trip) begin
            state_next = ST_FAULT;
            fault_next = 1'b1;
        end else if (i_stop && state_reg != ST_FAULT) begin
            state_next = ST_IDLE;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_reg <= ST_IDLE;
            ramp_cnt_reg <= 32'h0;
            amp_reg <= 16'h0000;
            fault_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ramp_cnt_reg <= ramp_cnt_next;
            amp_reg <= amp_next;
            fault_reg <= fault_next;
        end
    end

    // =====================================================
    // Carriers and line phase
    localparam int unsigned LINE_HALF = CLK_HZ / (2 * LINE_HZ);
    localparam int unsigned LSTEP = LINE_HALF / SINE_DEPTH;
    logic [CNT_W-1:0] car_reg, car_next, half_eff;
    logic dir_reg, dir_next;
    logic [15:0] lcnt_reg, lcnt_next;
    logic [SINE_AW-1:0] phase_reg, phase_next;
    logic pol_reg, pol_next;
    logic [15:0] sine_mag;
    logic active;
    assign active = state_reg == ST_RAMP || state_reg == ST_RUN;
    assign half_eff = clamp_half(i_half_period);

    always_comb begin
        car_next = car_reg;
        dir_next = dir_reg;
        lcnt_next = lcnt_reg;
        phase_next = phase_reg;
        pol_next = pol_reg;
        // Triangle carrier, one cycle per switching period
        if (dir_reg) begin
            if (car_reg >= half_eff - 1'b1) dir_next = 1'b0;
            else car_next = car_reg + 1'b1;
        end else begin
            if (car_reg == '0) dir_next = 1'b1;
            else car_next = car_reg - 1'b1;
        end
        if (car_reg > half_eff) car_next = half_eff;
        // Phase steps through half-sine; polarity flips each half
        if (lcnt_reg >= 16'(LSTEP - 1)) begin
            lcnt_next = 16'h0;
            phase_next = phase_reg + 1'b1;
            if (phase_reg == SINE_AW'(SINE_DEPTH - 1))
                pol_next = ~pol_reg;
        end else begin
            lcnt_next = lcnt_reg + 16'h1;
        end
        if (!active) begin
            lcnt_next = 16'h0;
            phase_next = '0;
            pol_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            car_reg <= '0;
            dir_reg <= 1'b1;
            lcnt_reg <= 16'h0;
            phase_reg <= '0;
            pol_reg <= 1'b1;
        end else begin
            car_reg <= car_next;
            dir_reg <= dir_next;
            lcnt_reg <= lcnt_next;
            phase_reg <= phase_next;
            pol_reg <= pol_next;
        end
    end

    sine_rom #(.DEPTH(SINE_DEPTH), .AW(SINE_AW)) u_rom (
        .i_clk_sys(i_clk_sys),
        .i_addr(phase_reg),
        .o_data(sine_mag)
    );

    // =====================================================
    // Comparison: reference is sine in positive half, 1-sine in negative
    logic [31:0] prod;
    logic [15:0] mag, ref_val;
    logic [CNT_W-1:0] ref_s, car_a, car_b;
    assign prod = 32'(sine_mag) * 32'(amp_reg);
    assign mag = prod[31:16];
    // Positive half: levels VDC..0, negative half: 0..-VDC
    assign ref_val = pol_reg ? mag : ~mag;
    assign ref_s = CNT_W'((32'(ref_val) * 32'(half_eff)) >> 16);
    assign car_a = car_reg;
    assign car_b = half_eff - car_reg;
    logic raw_a, raw_b;
    // One reference, two carriers; crossings alternate states 1/2, 5/6
    assign raw_a = ref_s > car_a;
    assign raw_b = ref_s > car_b;

    // =====================================================
    // Dead time and output stage
    logic [2:0] want;
    logic [5:0] gate;
    logic gate_off;
    assign want = {pol_reg, raw_a, raw_b};
    assign gate_off = !active || trip;
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ch
            logic cur_reg, cur_next, hi_reg, hi_next, lo_reg, lo_next;
            logic [7:0] dt_reg, dt_next;
            always_comb begin
                cur_next = cur_reg;
                dt_next = dt_reg;
                hi_next = 1'b0;
                lo_next = 1'b0;
                if (want[g] != cur_reg) begin
                    cur_next = want[g];
                    dt_next = i_dead_cycles;
                end else if (dt_reg != 8'h00) begin
                    dt_next = dt_reg - 8'h01;
                end else begin
                    hi_next = cur_reg;
                    lo_next = ~cur_reg;
                end
                if (want[g] != cur_reg) begin
                    hi_next = 1'b0;
                    lo_next = 1'b0;
                end
                if (gate_off) begin
                    hi_next = 1'b0;
                    lo_next = 1'b0;
                end
            end
            always_ff @(posedge i_clk_sys) begin
                if (!i_reset_n) begin
                    cur_reg <= 1'b0;
                    dt_reg <= 8'h00;
                    hi_reg <= 1'b0;
                    lo_reg <= 1'b0;
                end else begin
                    cur_reg <= cur_next;
                    dt_reg <= dt_next;
                    hi_reg <= hi_next;
                    lo_reg <= lo_next;
                end
            end
            // Combinational gate keeps trip-to-off within the cycle
            assign gate[2*g] = hi_reg & ~trip;
            assign gate[2*g+1] = lo_reg & ~trip;
        end
    endgenerate

    // Each output drives a series pair; legs take opposite devices
    assign o_cell_b_pwm = gate[0];
    assign o_cell_b_pwm_n = gate[1];
    assign o_cell_a_pwm = gate[2];
    assign o_cell_a_pwm_n = gate[3];
    assign o_polarity_select = gate[4];
    assign o_polarity_select_n = gate[5];

    assign o_running = active;
    assign o_startup_done = state_reg == ST_RUN;
    assign o_input_undervoltage_guard = uv;
    assign o_input_overvoltage_guard = ov;
    assign o_fault = fault_reg;
endmodule

// ==== src/gate_pwm_pkg.sv ====
package gate_pwm_pkg;
    // =====================================================
    // Clock and timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned LINE_HZ = 60;
    localparam int unsigned SW_HZ_MIN = 16_000;
    localparam int unsigned SW_HZ_MAX = 20_000;
    localparam int unsigned SW_HZ_DEFAULT = 20_000;
    // Half carrier period in cycles (triangle counts up then down)
    localparam int unsigned HALF_PERIOD_MAX = CLK_HZ / (2 * SW_HZ_MIN);
    localparam int unsigned HALF_PERIOD_MIN = CLK_HZ / (2 * SW_HZ_MAX);
    localparam int unsigned HALF_PERIOD_DEFAULT =
        CLK_HZ / (2 * SW_HZ_DEFAULT);
    // Start-up bound, longest time rounds down
    localparam int unsigned STARTUP_MS = 500;
    localparam int unsigned STARTUP_CYCLES = (CLK_HZ / 1000) * STARTUP_MS;
    localparam int unsigned RAMP_STEPS = 256;
    // Input range in volts
    localparam int unsigned VIN_MIN_V = 380;
    localparam int unsigned VIN_MAX_V = 420;
    localparam int unsigned DEAD_DEFAULT = 10;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned SINE_DEPTH = 256;
    localparam int unsigned SINE_AW = 8;

    // =====================================================
    // Run state
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RAMP = 2'b01,
        ST_RUN = 2'b10,
        ST_FAULT = 2'b11
    } run_state_type;
endpackage

// ==== src/sine_rom.sv ====
module sine_rom
    import gate_pwm_pkg::*;
#(
    parameter int unsigned DEPTH = SINE_DEPTH,
    parameter int unsigned AW = SINE_AW
) (
    input wire logic i_clk_sys,
    input wire logic [AW-1:0] i_addr,
    output logic [15:0] o_data
);
    // =====================================================
    // Half-sine magnitude table, fraction of full scale
    logic [15:0] table_mem [DEPTH];
    logic [15:0] data_reg;

    if (DEPTH != (1 << AW)) begin : g_bad_depth
        $error("sine_rom depth mismatch");
    end

    initial begin
        for (int k = 0; k < DEPTH; k++) begin
            table_mem[k] = 16'(int'($sin(3.14159265358979 * real'(k)
                / real'(DEPTH)) * 65535.0));
        end
    end

    always_ff @(posedge i_clk_sys) begin
        data_reg <= table_mem[i_addr];
    end

    assign o_data = data_reg;
endmodule

// ==== bench/gate_pwm_monitor.sv ====
module gate_pwm_monitor
    import gate_pwm_pkg::*;
#(
    parameter int unsigned STARTUP_LEN = STARTUP_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [7:0] i_dead_cycles,
    input wire logic [9:0] i_vin_volts,
    input wire logic i_overload,
    input wire logic i_short_circuit,
    input wire logic i_fault_clear,
    input wire logic o_polarity_select,
    input wire logic o_polarity_select_n,
    input wire logic o_cell_a_pwm,
    input wire logic o_cell_a_pwm_n,
    input wire logic o_cell_b_pwm,
    input wire logic o_cell_b_pwm_n,
    input wire logic o_running,
    input wire logic o_startup_done,
    input wire logic o_input_undervoltage_guard,
    input wire logic o_input_overvoltage_guard,
    input wire logic o_fault
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================
    // Helper logic
    logic trip;
    logic off;
    logic [31:0] ramp_reg;
    logic [31:0] ramp_next;
    assign trip = i_overload | i_short_circuit | (i_vin_volts < VIN_MIN_V)
        | (i_vin_volts > VIN_MAX_V);
    assign off = ~|{o_polarity_select, o_polarity_select_n, o_cell_a_pwm,
        o_cell_a_pwm_n, o_cell_b_pwm, o_cell_b_pwm_n};
    always_comb begin
        ramp_next = (o_running && !o_startup_done) ? ramp_reg + 1 : 32'h0;
    end
    always_ff @(posedge i_clk_sys) begin
        ramp_reg <= i_reset_n ? ramp_next : 32'h0;
    end
    // =========================================
    // Properties
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    property p_dead_pol;
        $fell(o_polarity_select) && i_dead_cycles != 8'h00
            |-> !o_polarity_select_n [*2];
    endproperty
    a_dead_pol: assert property (p_dead_pol)
        else $error("polarity pair dead time short");
    property p_dead_a;
        $rose(o_cell_a_pwm) && i_dead_cycles != 8'h00
            |-> $past(!o_cell_a_pwm_n) && $past(!o_cell_a_pwm_n, 2);
    endproperty
    a_dead_a: assert property (p_dead_a)
        else $error("cell a pair dead time short");
    property p_dead_b;
        $rose(o_cell_b_pwm_n) |-> $past(!o_cell_b_pwm, 2);
    endproperty
    a_dead_b: assert property (p_dead_b)
        else $error("cell b pair dead time short");
    property p_trip_off;
        trip |-> off;
    endproperty
    a_trip_off: assert property (p_trip_off)
        else $error("gates on during trip");
    property p_trip_fault;
        trip |=> o_fault && off;
    endproperty
    a_trip_fault: assert property (p_trip_fault)
        else $error("trip not latched");
    property p_fault_hold;
        o_fault && !i_fault_clear |=> o_fault;
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault released early");
    property p_guards;
        o_input_undervoltage_guard == (i_vin_volts < VIN_MIN_V)
            && o_input_overvoltage_guard == (i_vin_volts > VIN_MAX_V);
    endproperty
    a_guards: assert property (p_guards)
        else $error("input guard wrong");
    property p_start;
        i_start && !i_stop && !trip && !o_running && !o_fault |=> o_running;
    endproperty
    a_start: assert property (p_start)
        else $error("start not taken");
    property p_ramp;
        ramp_reg <= STARTUP_LEN + 2;
    endproperty
    a_ramp: assert property (p_ramp)
        else $error("start-up too long");
    c_done: cover property ($rose(o_startup_done));
    c_fault: cover property ($rose(o_fault));
    c_cell: cover property ($rose(o_cell_b_pwm));
endmodule

bind five_level_inverter_gate_pwm gate_pwm_monitor
    #(.STARTUP_LEN(STARTUP_LEN)) mon (.*);

// ==== bench/gate_driver_model.sv ====
module gate_driver_model (
    input wire logic i_pol,
    input wire logic i_pol_n,
    input wire logic i_a,
    input wire logic i_a_n,
    input wire logic i_b,
    input wire logic i_b_n,
    output int o_level,
    output logic o_shoot
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================
    // Bridge level and shoot-through watch
    always_comb begin
        o_level = int'(i_a) + int'(i_b) - (i_pol ? 0 : 2);
        o_shoot = (i_pol & i_pol_n) | (i_a & i_a_n) | (i_b & i_b_n);
    end
endmodule

// ==== bench/tb_five_level_inverter_gate_pwm.sv ====
module tb_five_level_inverter_gate_pwm;
    import gate_pwm_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned SLEN = 2560;
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_start = 1'b0;
    logic i_stop = 1'b0;
    logic i_overload = 1'b0;
    logic i_short_circuit = 1'b0;
    logic i_fault_clear = 1'b0;
    logic [CNT_W-1:0] i_half_period = 16'h04e2;
    logic [7:0] i_dead_cycles = 8'h04;
    logic [15:0] i_depth = 16'hc000;
    logic [9:0] i_vin_volts = 10'h190;
    logic o_polarity_select, o_polarity_select_n, o_running, o_fault;
    logic o_cell_a_pwm, o_cell_a_pwm_n, o_cell_b_pwm, o_cell_b_pwm_n;
    logic o_startup_done, o_input_undervoltage_guard;
    logic o_input_overvoltage_guard, o_shoot, trip, exp_fault;
    logic [5:0] gates;
    logic [31:0] seed = 32'hdf8dad99;
    int o_level, h_set, cycles, mismatches, total_checks;
    assign gates = {o_polarity_select, o_polarity_select_n, o_cell_a_pwm,
        o_cell_a_pwm_n, o_cell_b_pwm, o_cell_b_pwm_n};
    assign trip = i_overload | i_short_circuit | (i_vin_volts < VIN_MIN_V)
        | (i_vin_volts > VIN_MAX_V);

    five_level_inverter_gate_pwm #(.STARTUP_LEN(SLEN)) dut (.*);
    gate_driver_model bridge (
        .i_pol(o_polarity_select),
        .i_pol_n(o_polarity_select_n),
        .i_a(o_cell_a_pwm),
        .i_a_n(o_cell_a_pwm_n),
        .i_b(o_cell_b_pwm),
        .i_b_n(o_cell_b_pwm_n),
        .o_level(o_level),
        .o_shoot(o_shoot)
    );
    // =========================================
    // Checking and closing
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // =========================================
    // Reference model and clock
    initial forever #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cycles++;
        if (!i_reset_n || (i_fault_clear && !trip)) exp_fault <= 1'b0;
        else if (trip) exp_fault <= 1'b1;
        if (cycles == 100000) begin
            mismatches++;
            summarize();
        end
    end
    always @(negedge i_clk_sys) if (i_reset_n) begin
        check(o_input_undervoltage_guard, i_vin_volts < VIN_MIN_V);
        check(o_input_overvoltage_guard, i_vin_volts > VIN_MAX_V);
        check(o_fault, exp_fault);
        check(o_shoot, 1'b0);
        if (trip) check(gates, 6'h00);
    end
    // =========================================
    // Stimulus tasks
    task automatic rest();
        @(posedge i_clk_sys);
        i_start <= 1'b0;
        i_overload <= 1'b0;
        i_short_circuit <= 1'b0;
        i_vin_volts <= 10'h190;
        i_stop <= 1'b1;
        i_fault_clear <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_stop <= 1'b0;
        i_fault_clear <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic run_up();
        int n;
        seed = lfsr(seed);
        h_set = 1250 + seed[15:0] % 313;
        @(posedge i_clk_sys);
        i_half_period <= 16'(h_set);
        i_dead_cycles <= {4'h0, seed[19:16]} | 8'h01;
        i_depth <= {1'b1, seed[30:16]};
        i_start <= 1'b1;
        @(posedge i_clk_sys);
        i_start <= 1'b0;
        @(negedge i_clk_sys);
        check(o_running, 1'b1);
        n = 0;
        while (!o_startup_done && n < SLEN + 300) begin
            @(negedge i_clk_sys);
            n++;
        end
        check(n <= SLEN + 2, 1'b1);
    endtask
    // =========================================
    // Main sequence
    initial begin
        logic [9:0] vins [4] = '{10'h17b, 10'h17c, 10'h1a4, 10'h1a5};
        int na, nb, s2, s3, e;
        logic pa, pb, ok;
        repeat (4) @(posedge i_clk_sys);
        i_reset_n <= 1'b1;
        @(negedge i_clk_sys);
        check(gates, 6'h00);
        foreach (vins[k]) begin
            @(posedge i_clk_sys);
            i_vin_volts <= vins[k];
            i_start <= 1'b1;
            repeat (2) @(posedge i_clk_sys);
            @(negedge i_clk_sys);
            ok = vins[k] >= VIN_MIN_V && vins[k] <= VIN_MAX_V;
            check(o_running, ok);
            rest();
        end
        $display("input range test done");
        run_up();
        repeat (40000) @(posedge i_clk_sys);
        {na, nb, s2, s3} = '0;
        pa = o_cell_a_pwm;
        pb = o_cell_b_pwm;
        repeat (20000) begin
            @(negedge i_clk_sys);
            na += int'(o_cell_a_pwm && !pa);
            nb += int'(o_cell_b_pwm && !pb);
            pa = o_cell_a_pwm;
            pb = o_cell_b_pwm;
            if (o_level == 1 || o_level == -1) begin
                s2 += int'(o_cell_a_pwm && !o_cell_b_pwm);
                s3 += int'(!o_cell_a_pwm && o_cell_b_pwm);
            end
        end
        e = 20000 / (2 * h_set);
        check(na >= e - 1 && na <= e + 1, 1'b1);
        check(nb >= e - 1 && nb <= e + 1, 1'b1);
        check(s2 > 0 && s3 > 0, 1'b1);
        check(o_polarity_select, 1'b1);
        $display("modulation test done");
        for (int k = 0; k < 2; k++) begin
            rest();
            run_up();
            repeat (200) @(posedge i_clk_sys);
            if (k == 0) i_overload <= 1'b1;
            else i_short_circuit <= 1'b1;
            @(negedge i_clk_sys);
            check(gates, 6'h00);
            repeat (3) @(posedge i_clk_sys);
        end
        rest();
        $display("protection test done");
        summarize();
    end
endmodule
